// file: hdl/usart_receiver.sv
// Serial receiver: async x16 recovery, sync master receive, two-deep FIFO, AXI4-Lite registers
// Function
// R1 - Async mode recovers bits with x16 oversampling; main shifter advances once per bit.
// R2 - Async reception runs only while continuous receive enable is set.
// R3 - After stop bit, shift word goes to FIFO if room; receive flag set.
// R4 - Receive flag read-only; clears when data read and FIFO empty.
// R5 - FIFO holds two words; a third may shift in meanwhile.
// R6 - Async: FIFO full at third stop bit sets overrun, word dropped.
// R7 - Overrun blocks FIFO transfers; cleared by clearing continuous enable.
// R8 - Async: stop bit sampled zero sets framing error.
// R9 - Framing error and ninth bit queue with each word; read advances them.
// R10 - Software reads status before data to keep ninth bit and error.
// R11 - Sync mode starts on single or continuous receive enable.
// R12 - Sync mode samples data pin at serial clock falling edge.
// R13 - Single enable receives one word; continuous receives until cleared.
// R14 - Both enables set behaves as continuous reception.
// R15 - Sync: FIFO full at third word's last bit sets overrun, word lost.
// R16 - Software programs divisor, mode bits, then single or continuous enable.
// R17 - Software clears errors by clearing continuous enable.
// R18 - Software sets global and peripheral interrupt enables for processor interrupts; irq here is not gated by either enable.
// R19 - Sync master drives serial clock from baud generator only while receiving.
`timescale 1ns/10ps
`default_nettype none
module usart_receiver
  import usart_rx_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic receive_data_pin,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic irq
);
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (addr[1:0] == 2'b00);
  endfunction : reg_hit

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_W'(1);
  endfunction : ptr_inc

  logic aw_have_reg, w_have_reg, awready_reg, wready_reg, bvalid_reg;
  logic arready_reg, rvalid_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic gie_reg, peripheral_interrupt_enable_reg, serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, receive_interrupt_enable_reg, clock_source_master_reg, sync_reg;
  logic [7:0] baud_reg, div_reg;
  logic [INT_W-1:0] int_status_reg, int_enable_reg;
  logic overrun_error_reg, irq_reg, rx_meta_reg, rx_s_reg;
  rx_state_t state_reg;
  logic [3:0] os_reg, bit_reg;
  logic [8:0] sh_reg;
  logic sclk_reg, sclk_oe_reg;
  rx_word_t fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CNT_W-1:0] cnt_reg;

  logic w_go, we, ar_hs, pop, tick, async_on, sync_on;
  logic async_stop, sync_fall, sync_last, word_done, full, push, ovr_evt, framing_error_evt;
  logic [3:0] last_bit;
  logic [8:0] new_sh, word_sh;
  rx_word_t push_word, head;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic [INT_W-1:0] int_clr, int_evt;

  // Bus handshake decode
  assign w_go = aw_have_reg && w_have_reg && !bvalid_reg;
  assign we = w_go && w_lane0_reg;
  assign ar_hs = arvalid && arready_reg;
  assign pop = ar_hs && reg_hit(araddr, IDX_RECEIVE_DATA) && (cnt_reg != '0);

  // Write channels taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= RST_BYTE;
      w_lane0_reg <= 1'b0;
    end else begin
      if (awvalid && awready_reg) begin
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= wdata[7:0];
        w_lane0_reg <= wstrb[0];
      end
      if (w_go) begin
        bvalid_reg <= 1'b1;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Control registers; single enable self-clears after its word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {gie_reg, peripheral_interrupt_enable_reg, serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg} <= '0;
      {receive_interrupt_enable_reg, clock_source_master_reg, sync_reg} <= '0;
      baud_reg <= RST_BYTE;
      int_enable_reg <= '0;
    end else begin
      if (sync_last && !continuous_receive_enable_reg) begin
        single_receive_enable_reg <= 1'b0; // R13
      end
      if (we && reg_hit(aw_addr_reg, IDX_INTERRUPT_CONTROL)) begin
        gie_reg <= w_data_reg[B_GIE];
        peripheral_interrupt_enable_reg <= w_data_reg[B_PERIPHERAL_INTERRUPT_ENABLE];
      end
      if (we && reg_hit(aw_addr_reg, IDX_RECEIVE_STATUS_CONTROL)) begin
        serial_port_enable_reg <= w_data_reg[B_SERIAL_PORT_ENABLE];
        rx9_reg <= w_data_reg[B_RX9];
        single_receive_enable_reg <= w_data_reg[B_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable_reg <= w_data_reg[B_CONTINUOUS_RECEIVE_ENABLE];
      end
      if (we && reg_hit(aw_addr_reg, IDX_PERIPHERAL_ENABLES_1)) begin
        receive_interrupt_enable_reg <= w_data_reg[B_RECEIVE_INTERRUPT_ENABLE];
      end
      if (we && reg_hit(aw_addr_reg, IDX_TRANSMIT_STATUS_CONTROL)) begin
        clock_source_master_reg <= w_data_reg[B_CLOCK_SOURCE_MASTER];
        sync_reg <= w_data_reg[B_SYNC];
      end
      if (we && reg_hit(aw_addr_reg, IDX_BAUD_DIVISOR)) begin
        baud_reg <= w_data_reg;
      end
      if (we && reg_hit(aw_addr_reg, IDX_INT_ENABLE)) begin
        int_enable_reg <= w_data_reg[INT_W-1:0];
      end
    end
  end

  // Read mux; status bits show the FIFO head word
  always_comb begin
    rd_byte = RST_BYTE;
    rd_ok = 1'b1;
    if (reg_hit(araddr, IDX_INTERRUPT_CONTROL)) begin
      rd_byte[B_GIE] = gie_reg;
      rd_byte[B_PERIPHERAL_INTERRUPT_ENABLE] = peripheral_interrupt_enable_reg;
    end else if (reg_hit(araddr, IDX_PERIPHERAL_FLAGS_1)) begin
      rd_byte[B_RCFLAG] = (cnt_reg != '0); // R4
    end else if (reg_hit(araddr, IDX_RECEIVE_STATUS_CONTROL)) begin
      rd_byte[B_SERIAL_PORT_ENABLE] = serial_port_enable_reg;
      rd_byte[B_RX9] = rx9_reg;
      rd_byte[B_SINGLE_RECEIVE_ENABLE] = single_receive_enable_reg;
      rd_byte[B_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable_reg;
      rd_byte[B_FRAMING_ERROR] = (cnt_reg != '0) && head.framing_error; // R9
      rd_byte[B_OVERRUN_ERROR] = overrun_error_reg;
      rd_byte[B_RECEIVED_NINTH_BIT] = (cnt_reg != '0) && head.ninth; // R9
    end else if (reg_hit(araddr, IDX_RECEIVE_DATA)) begin
      rd_byte = (cnt_reg != '0) ? head.data : RST_BYTE;
    end else if (reg_hit(araddr, IDX_PERIPHERAL_ENABLES_1)) begin
      rd_byte[B_RECEIVE_INTERRUPT_ENABLE] = receive_interrupt_enable_reg;
    end else if (reg_hit(araddr, IDX_TRANSMIT_STATUS_CONTROL)) begin
      rd_byte[B_CLOCK_SOURCE_MASTER] = clock_source_master_reg;
      rd_byte[B_SYNC] = sync_reg;
      rd_byte[B_TRANSMIT_SHIFT_EMPTY] = 1'b1;
    end else if (reg_hit(araddr, IDX_BAUD_DIVISOR)) begin
      rd_byte = baud_reg;
    end else if (reg_hit(araddr, IDX_INT_STATUS)) begin
      rd_byte[INT_W-1:0] = int_status_reg;
    end else if (reg_hit(araddr, IDX_INT_ENABLE)) begin
      rd_byte[INT_W-1:0] = int_enable_reg;
    end else if (!reg_hit(araddr, IDX_INT_CLEAR)) begin
      rd_ok = 1'b0;
    end
  end

  // Read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Data pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_reg <= 1'b1;
      rx_s_reg <= 1'b1;
    end else begin
      rx_meta_reg <= receive_data_pin;
      rx_s_reg <= rx_meta_reg;
    end
  end

  // Baud generator: tick every divisor+1 clocks
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_port_enable_reg || (div_reg == baud_reg)) begin
      div_reg <= RST_BYTE;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign tick = serial_port_enable_reg && (div_reg == baud_reg);

  // Mode qualifiers and word completion
  assign async_on = serial_port_enable_reg && !sync_reg && continuous_receive_enable_reg; // R2
  assign sync_on = serial_port_enable_reg && sync_reg && clock_source_master_reg && (single_receive_enable_reg || continuous_receive_enable_reg); // R11
  assign last_bit = rx9_reg ? LAST_BIT_9 : LAST_BIT_8;
  assign new_sh = {rx_s_reg, sh_reg[8:1]};
  assign async_stop = (state_reg == ST_STOP) && tick && (os_reg == OS_LAST) && async_on;
  assign sync_fall = (state_reg == ST_DATA) && sync_reg && tick && sclk_reg; // R12
  assign sync_last = sync_fall && (bit_reg == last_bit);
  assign word_done = async_stop || sync_last;
  assign word_sh = sync_last ? new_sh : sh_reg;
  assign framing_error_evt = async_stop && !rx_s_reg; // R8
  assign push_word.framing_error = framing_error_evt;
  assign push_word.ninth = rx9_reg && word_sh[8];
  assign push_word.data = rx9_reg ? word_sh[7:0] : word_sh[8:1];
  assign full = (cnt_reg == CNT_FULL);
  assign push = word_done && !overrun_error_reg && !full; // R3 R7
  assign ovr_evt = word_done && !overrun_error_reg && full; // R6 R15

  // Receive state machine for both modes
  always_ff @(posedge aclk) begin
    if (!aresetn || !(async_on || sync_on)) begin
      state_reg <= ST_IDLE; // R2
      os_reg <= '0;
      bit_reg <= '0;
      sh_reg <= '0;
      sclk_reg <= 1'b0;
      sclk_oe_reg <= 1'b0; // R19
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (sync_on) begin
            state_reg <= ST_DATA; // R11
            bit_reg <= '0;
            sclk_reg <= 1'b0;
            sclk_oe_reg <= 1'b1; // R19
          end else if (tick && !rx_s_reg) begin
            state_reg <= ST_START;
            os_reg <= '0;
          end
        end
        ST_START: begin
          if (tick) begin
            os_reg <= os_reg + 4'h1; // R1
            if (os_reg == OS_MID) begin
              os_reg <= '0;
              bit_reg <= '0;
              state_reg <= rx_s_reg ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sync_reg && tick) begin
            sclk_reg <= !sclk_reg; // R19
            if (sclk_reg) begin
              sh_reg <= new_sh; // R12
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == last_bit) begin
                bit_reg <= '0;
                if (!continuous_receive_enable_reg) begin
                  state_reg <= ST_IDLE; // R13 R14
                  sclk_oe_reg <= 1'b0;
                end
              end
            end
          end else if (!sync_reg && tick) begin
            os_reg <= os_reg + 4'h1; // R1
            if (os_reg == OS_LAST) begin
              sh_reg <= new_sh; // R1
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == last_bit) begin
                state_reg <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            os_reg <= os_reg + 4'h1;
            if (os_reg == OS_LAST) begin
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Overrun flag; cleared by dropping continuous enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_error_reg <= 1'b0;
    end else if (ovr_evt) begin
      overrun_error_reg <= 1'b1; // R6 R15
    end else if (!continuous_receive_enable_reg) begin
      overrun_error_reg <= 1'b0; // R7
    end
  end

  // Two-deep receive FIFO with queued status
  assign head = fifo_mem[rd_ptr_reg];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= push_word; // R5 R9
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg); // R9
      end
      cnt_reg <= cnt_reg + CNT_W'(push) - CNT_W'(pop); // R4
    end
  end

  // Sticky interrupt status, set wins over clear
  assign int_clr = (we && reg_hit(aw_addr_reg, IDX_INT_CLEAR)) ? w_data_reg[INT_W-1:0] : '0;
  always_comb begin
    int_evt = '0;
    int_evt[INT_RX] = push;
    int_evt[INT_OVR] = ovr_evt;
    int_evt[INT_FRM] = framing_error_evt;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      int_status_reg <= (int_status_reg & ~int_clr) | int_evt;
      irq_reg <= (|(int_status_reg & int_enable_reg)) || ((cnt_reg != '0) && receive_interrupt_enable_reg); // R3
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bresp = RESP_OKAY;
  assign bvalid = bvalid_reg;
  assign arready = arready_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign rvalid = rvalid_reg;
  assign serial_clock_out = sclk_reg;
  assign serial_clock_oe = sclk_oe_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_push_flag;
    push |=> (cnt_reg != '0);
  endproperty
  a_push_flag: assert property (p_push_flag) else $error("flag not set after store"); // R3
  property p_flag_clear;
    pop && !push && (cnt_reg == CNT_W'(1)) |=> (cnt_reg == '0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared on last read"); // R4
  property p_depth;
    cnt_reg <= CNT_FULL;
  endproperty
  a_depth: assert property (p_depth) else $error("fifo count beyond depth"); // R5
  property p_overrun;
    word_done && full && !overrun_error_reg && !pop |=> overrun_error_reg && (cnt_reg == CNT_FULL);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R6
  property p_block;
    overrun_error_reg |-> !push;
  endproperty
  a_block: assert property (p_block) else $error("store while overrun"); // R7
  property p_framing_error;
    push && async_stop |-> (push_word.framing_error == !rx_s_reg);
  endproperty
  a_framing_error: assert property (p_framing_error) else $error("framing bit wrong"); // R8
  property p_async_gate;
    !sync_reg && !continuous_receive_enable_reg |=> (state_reg == ST_IDLE);
  endproperty
  a_async_gate: assert property (p_async_gate) else $error("async receive without enable"); // R2
  property p_single;
    sync_last && !continuous_receive_enable_reg |=> !single_receive_enable_reg && (state_reg == ST_IDLE) && !sclk_oe_reg;
  endproperty
  a_single: assert property (p_single) else $error("single receive did not stop"); // R13
  property p_cont;
    sync_last && continuous_receive_enable_reg && sync_on |=> (state_reg == ST_DATA) && sclk_oe_reg;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous receive stopped"); // R14
  property p_sclk;
    sclk_oe_reg |-> sync_reg && serial_port_enable_reg && (state_reg == ST_DATA);
  endproperty
  a_sclk: assert property (p_sclk) else $error("clock driven while idle"); // R19
endmodule : usart_receiver
`default_nettype wire

// file: hdl/usart_rx_pkg.sv
// Constants, register map and types for the serial receive block
`default_nettype none
package usart_rx_pkg;
  localparam int ADDR_W = 12;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
  localparam logic [9:0] IDX_PERIPHERAL_FLAGS_1 = 10'h00c;
  localparam logic [9:0] IDX_RECEIVE_STATUS_CONTROL = 10'h018;
  localparam logic [9:0] IDX_RECEIVE_DATA = 10'h01a;
  localparam logic [9:0] IDX_PERIPHERAL_ENABLES_1 = 10'h08c;
  localparam logic [9:0] IDX_TRANSMIT_STATUS_CONTROL = 10'h098;
  localparam logic [9:0] IDX_BAUD_DIVISOR = 10'h099;
  localparam logic [9:0] IDX_INT_STATUS = 10'h0a0;
  localparam logic [9:0] IDX_INT_CLEAR = 10'h0a1;
  localparam logic [9:0] IDX_INT_ENABLE = 10'h0a2;
  // Bit positions
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int B_RCFLAG = 5;
  localparam int B_RECEIVE_INTERRUPT_ENABLE = 5;
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_RX9 = 6;
  localparam int B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int B_FRAMING_ERROR = 2;
  localparam int B_OVERRUN_ERROR = 1;
  localparam int B_RECEIVED_NINTH_BIT = 0;
  localparam int B_CLOCK_SOURCE_MASTER = 7;
  localparam int B_SYNC = 4;
  localparam int B_TRANSMIT_SHIFT_EMPTY = 1;
  // Interrupt status layout
  localparam int INT_W = 3;
  localparam int INT_RX = 0;
  localparam int INT_OVR = 1;
  localparam int INT_FRM = 2;
  // Oversampling and bit counts
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic framing_error;
    logic ninth;
    logic [7:0] data;
  } rx_word_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11,
    ST_STOP = 2'b10
  } rx_state_t;
endpackage : usart_rx_pkg
`default_nettype wire

// file: verif/serial_tx_model.sv
// Remote serial transmitter model that drives the receive data pin
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model (
  input wire logic aclk,
  input wire logic sclk,
  output logic line
);
  logic [8:0] sq[$];
  int bi = 0;
  int bit_clks = 16;
  initial line = 1'b1;

  // Async frame: start low, data LSB first, stop, one idle bit high
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    for (int k = -1; k <= nb + 1; k++) begin
      @(posedge aclk);
      line <= (k < 0) ? 1'b0 : (k < nb) ? d[k] : (k == nb) ? stop : 1'b1;
      repeat (bit_clks - 1) @(posedge aclk);
    end
  endtask : send

  // Sync words change on serial clock rise; junk once the queue is empty
  always @(posedge sclk) begin
    if (sq.size() > 0) begin
      line <= sq[0][bi];
      bi = bi + 1;
      if (bi == 8) begin
        bi = 0;
        void'(sq.pop_front());
      end
    end else begin
      line <= ~line;
    end
  end
endmodule : serial_tx_model
`default_nettype wire

// file: verif/tb_usart_receiver.sv
// Self-checking bench for the serial receive block
`timescale 1ns/10ps
`default_nettype none
module tb_usart_receiver;
  import usart_rx_pkg::*;
  typedef struct packed {
    logic we;
    logic [11:0] a;
    logic [7:0] wd;
    logic [7:0] exp;
    logic [1:0] resp;
  } row_t;
  localparam logic [11:0] A_ICON = {IDX_INTERRUPT_CONTROL, 2'b00};
  localparam logic [11:0] A_FLG = {IDX_PERIPHERAL_FLAGS_1, 2'b00};
  localparam logic [11:0] A_RCS = {IDX_RECEIVE_STATUS_CONTROL, 2'b00};
  localparam logic [11:0] A_DAT = {IDX_RECEIVE_DATA, 2'b00};
  localparam logic [11:0] A_PIE = {IDX_PERIPHERAL_ENABLES_1, 2'b00};
  localparam logic [11:0] A_TXS = {IDX_TRANSMIT_STATUS_CONTROL, 2'b00};
  localparam logic [11:0] A_BAUD = {IDX_BAUD_DIVISOR, 2'b00};
  localparam logic [11:0] A_IST = {IDX_INT_STATUS, 2'b00};
  localparam logic [11:0] A_ICLR = {IDX_INT_CLEAR, 2'b00};
  localparam logic [11:0] A_IEN = {IDX_INT_ENABLE, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = 12'h000;
  logic [ADDR_W-1:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sclk, sclk_oe, irq, pin;
  logic [1:0] bresp, rresp, rd_r;
  logic [31:0] rdata, rd_v;
  int bad_count = 0;
  int samples_checked = 0;
  row_t rows [9] = '{
    '{1'b0, A_FLG, 8'h00, 8'h00, RESP_OKAY},
    '{1'b0, A_DAT, 8'h00, 8'h00, RESP_OKAY},
    '{1'b0, A_TXS, 8'h00, 8'h02, RESP_OKAY},
    '{1'b1, A_BAUD, 8'ha5, 8'ha5, RESP_OKAY},
    '{1'b1, A_PIE, 8'h20, 8'h20, RESP_OKAY},
    '{1'b1, A_ICON, 8'hc0, 8'hc0, RESP_OKAY},
    '{1'b1, A_FLG, 8'hff, 8'h00, RESP_OKAY},
    '{1'b1, A_ICLR, 8'h07, 8'h00, RESP_OKAY},
    '{1'b0, 12'hffc, 8'h00, 8'h00, RESP_SLVERR}
  };

  // Clock, 5 ns period
  always #2.5 aclk = ~aclk;

  usart_receiver u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .receive_data_pin(pin),
    .serial_clock_out(sclk), .serial_clock_oe(sclk_oe), .irq(irq)
  );

  serial_tx_model u_tx (.aclk(aclk), .sclk(sclk), .line(pin));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        chk(32'(bresp), 32'(RESP_OKAY));
      end
    end
    bready <= 1'b0;
    chk(32'(done), 32'h1);
  endtask : wr

  // Bus read, data and response kept
  task automatic rd(input logic [11:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rd_v = rdata;
        rd_r = rresp;
      end
    end
    rready <= 1'b0;
    chk(32'(done), 32'h1);
  endtask : rd

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    rd(a);
    chk(rd_v, {24'h00_0000, exp});
  endtask : rdc

  // Interrupt line after a three-cycle wait
  task automatic irqc(input logic exp);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'(exp));
  endtask : irqc

  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // Watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({awready, sclk_oe, irq}), 32'h4);
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].wd);
      rd(rows[i].a);
      chk(rd_v, {24'h00_0000, rows[i].exp});
      chk(32'(rd_r), 32'(rows[i].resp));
    end
    wr(A_BAUD, 8'h00);
    wr(A_RCS, 8'h80);
    u_tx.send(9'h0a5, 8, 1'b1);
    rdc(A_FLG, 8'h00);
    wr(A_IEN, 8'h07);
    wr(A_RCS, 8'h90);
    u_tx.send(9'h05a, 8, 1'b1);
    rdc(A_FLG, 8'h20);
    irqc(1'b1);
    u_tx.send(9'h0c3, 8, 1'b0);
    u_tx.send(9'h011, 8, 1'b1);
    rdc(A_RCS, 8'h92);
    rdc(A_DAT, 8'h5a);
    rdc(A_RCS, 8'h96);
    rdc(A_DAT, 8'hc3);
    rdc(A_FLG, 8'h00);
    u_tx.send(9'h033, 8, 1'b1);
    rdc(A_FLG, 8'h00);
    rdc(A_IST, 8'h07);
    wr(A_IEN, 8'h00);
    irqc(1'b0);
    wr(A_IEN, 8'h07);
    irqc(1'b1);
    wr(A_ICLR, 8'h07);
    rdc(A_IST, 8'h00);
    irqc(1'b0);
    wr(A_RCS, 8'h80);
    rdc(A_RCS, 8'h80);
    wr(A_RCS, 8'hd0);
    u_tx.send(9'h13c, 9, 1'b1);
    rdc(A_RCS, 8'hd1);
    rdc(A_DAT, 8'h3c);
    // Sync master: single word, then both enables
    wr(A_RCS, 8'h80);
    wr(A_BAUD, 8'h03);
    wr(A_TXS, 8'h90);
    u_tx.sq.push_back(9'h0b6);
    wr(A_RCS, 8'ha0);
    repeat (20) @(posedge aclk);
    chk(32'(sclk_oe), 32'h1);
    repeat (100) @(posedge aclk);
    chk(32'(sclk_oe), 32'h0);
    rdc(A_RCS, 8'h80);
    rdc(A_DAT, 8'hb6);
    u_tx.sq.push_back(9'h081);
    u_tx.sq.push_back(9'h042);
    u_tx.sq.push_back(9'h024);
    wr(A_RCS, 8'hb0);
    repeat (260) @(posedge aclk);
    rdc(A_RCS, 8'hb2);
    rdc(A_DAT, 8'h81);
    rdc(A_DAT, 8'h42);
    wr(A_RCS, 8'h80);
    repeat (20) @(posedge aclk);
    chk(32'({sclk_oe, sclk}), 32'h0);
    // Mid-run reset: outputs back to idle, control cleared
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'({awready, wready, arready, bvalid, rvalid, sclk_oe, irq}), 32'h70);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(A_RCS, 8'h00);
    summarize();
  end
endmodule : tb_usart_receiver
`default_nettype wire
